// ===== common/pbt_defs.svh
// Constants for the pattern buffer trigger output block.
// Function
// - Drive trigger while pattern shown, capturable.
// - Drive pattern flip to invert buffered bit.
// - Two read-slot lines name one of four.
// - Sample strap at reset release: 1Bh/1Dh.
// - Shared strap pin input at release, output later.
// - Outputs low and inactive during flash load.
// - Outputs stay inactive until enable write.
// - Pulse slot advance to move to next buffer.
`ifndef PBT_DEFS_SVH
`define PBT_DEFS_SVH
`define PBT_ADDR_STRAP_LOW 7'h1b
`define PBT_ADDR_STRAP_HIGH 7'h1d
`define PBT_SLOT_RESET 2'h0
`define PBT_STRAP_SETTLE 2'h2
`define PBT_ADVANCE_PULSE_CYCLES 8'h01
`endif

// ===== common/pbt_pkg.sv
// Types for the pattern buffer trigger output block.
package pbt_pkg;
	typedef enum logic [1:0] {
		PBT_STRAP = 2'b00,
		PBT_LOAD = 2'b01,
		PBT_IDLE = 2'b10,
		PBT_RUN = 2'b11
	} pbt_state_t;
	typedef struct packed {
		logic trigger;
		logic pattern_flip;
		logic [1:0] read_slot;
		logic slot_advance;
	} pbt_pins_t;
endpackage

// ===== design/pbt_outputs.sv
// Side-band trigger, flip, read-slot and slot-advance outputs.
`timescale 1ns/1ps
`include "pbt_defs.svh"
module pbt_outputs (
	input wire logic clk,
	input wire logic nrst,
	input wire logic strap_in,
	input wire logic flash_loading,
	input wire logic enable_write,
	input wire logic enable_value,
	input wire logic show_pattern,
	input wire logic flip_request,
	input wire logic advance_request,
	output logic [6:0] slave_addr,
	output logic addr_valid,
	output logic trigger,
	output logic pattern_flip,
	output logic read_slot_bit0,
	output logic read_slot_bit1,
	output logic read_slot_bit1_oe,
	output logic slot_advance
);
	logic strap_sync;
	pbt_pkg::pbt_state_t state;
	pbt_pkg::pbt_state_t next_state;
	pbt_pkg::pbt_pins_t pins;
	pbt_pkg::pbt_pins_t next_pins;
	logic [6:0] next_slave_addr;
	logic next_addr_valid;
	logic next_oe;
	logic enabled;
	logic next_enabled;
	logic [1:0] strap_wait;
	logic [1:0] next_strap_wait;

	pbt_sync u_strap (
		.clk(clk),
		.nrst(nrst),
		.din(strap_in),
		.dout(strap_sync)
	);

	always_comb begin
		next_state = state;
		next_pins = pins;
		next_slave_addr = slave_addr;
		next_addr_valid = addr_valid;
		next_oe = read_slot_bit1_oe;
		next_enabled = enabled;
		next_strap_wait = strap_wait;
		next_pins.slot_advance = 1'b0;
		case (state)
			pbt_pkg::PBT_STRAP: begin
				// The strap is read only once the synchroniser has settled.
				if (strap_wait == `PBT_STRAP_SETTLE) begin
					next_slave_addr = strap_sync ? `PBT_ADDR_STRAP_HIGH :
						`PBT_ADDR_STRAP_LOW;
					next_addr_valid = 1'b1;
					next_state = pbt_pkg::PBT_LOAD;
				end else begin
					next_strap_wait = 2'(strap_wait + 2'h1);
				end
			end
			pbt_pkg::PBT_LOAD: begin
				next_pins = '0;
				next_oe = 1'b1;
				if (!flash_loading) begin
					next_state = pbt_pkg::PBT_IDLE;
				end
			end
			pbt_pkg::PBT_IDLE: begin
				next_pins = '0;
				if (enable_write && enable_value) begin
					next_enabled = 1'b1;
					next_state = pbt_pkg::PBT_RUN;
				end
			end
			pbt_pkg::PBT_RUN: begin
				next_pins.trigger = show_pattern;
				next_pins.pattern_flip = flip_request;
				if (advance_request) begin
					next_pins.slot_advance = 1'b1;
					next_pins.read_slot = 2'(pins.read_slot + 2'h1);
				end
				if (enable_write && !enable_value) begin
					next_enabled = 1'b0;
					next_pins = '0;
					next_state = pbt_pkg::PBT_IDLE;
				end
			end
			default: begin
				next_state = pbt_pkg::PBT_LOAD;
			end
		endcase
		if (flash_loading && state != pbt_pkg::PBT_STRAP) begin
			next_pins = '0;
			next_enabled = 1'b0;
			next_state = pbt_pkg::PBT_LOAD;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= pbt_pkg::PBT_STRAP;
			pins <= '0;
			slave_addr <= `PBT_ADDR_STRAP_LOW;
			addr_valid <= 1'b0;
			read_slot_bit1_oe <= 1'b0;
			enabled <= 1'b0;
			strap_wait <= 2'h0;
		end else begin
			strap_wait <= next_strap_wait;
			state <= next_state;
			pins <= next_pins;
			slave_addr <= next_slave_addr;
			addr_valid <= next_addr_valid;
			read_slot_bit1_oe <= next_oe;
			enabled <= next_enabled;
		end
	end

	always_comb begin
		trigger = pins.trigger;
		pattern_flip = pins.pattern_flip;
		read_slot_bit0 = pins.read_slot[0];
		read_slot_bit1 = pins.read_slot[1];
		slot_advance = pins.slot_advance;
	end
endmodule

// ===== design/pbt_sync.sv
// Two-flop synchroniser for a pin input.
`timescale 1ns/1ps
module pbt_sync (
	input wire logic clk,
	input wire logic nrst,
	input wire logic din,
	output logic dout
);
	logic stage1;
	logic next_stage1;
	logic next_dout;
	always_comb begin
		next_stage1 = din;
		next_dout = stage1;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage1 <= 1'b0;
			dout <= 1'b0;
		end else begin
			stage1 <= next_stage1;
			dout <= next_dout;
		end
	end
endmodule

// ===== tb/pbt_companion.sv
// Companion model: strap pull on the shared pin and a swap counter.
`timescale 1ns/1ps
module pbt_companion(
	input wire logic clk, nrst, pull, oe, hi, swap,
	output logic line,
	output logic [1:0] seen
);
	assign line = oe ? hi : pull;
	always_ff @(posedge clk or negedge nrst)
		if (!nrst) seen <= 2'h0;
		else if (swap) seen <= seen + 2'h1;
endmodule

// ===== tb/pbt_props.sv
// Checker for the side-band output block.
`timescale 1ns/1ps
module pbt_props(
	input wire logic clk, nrst, strap_in, flash_loading, trigger,
	input wire logic show_pattern, flip_request, advance_request,
	input wire logic addr_valid, pattern_flip, slot_advance,
	input wire logic read_slot_bit0, read_slot_bit1, read_slot_bit1_oe,
	input wire logic [6:0] slave_addr
);
	wire logic [1:0] s = {read_slot_bit1, read_slot_bit0};
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_load_low: assert property (flash_loading |=>
		!trigger && !pattern_flip && !slot_advance) else $error("load");
	a_trig_cause: assert property ($rose(trigger) |->
		$past(show_pattern)) else $error("trig");
	a_flip_cause: assert property ($rose(pattern_flip) |->
		$past(flip_request)) else $error("flip");
	a_adv_cause: assert property (slot_advance |->
		$past(advance_request)) else $error("adv");
	a_slot_step: assert property (slot_advance |->
		s == 2'($past(s) + 2'h1)) else $error("slot");
	a_addr_pick: assert property ($rose(addr_valid) |->
		slave_addr == (strap_in ? 7'h1d : 7'h1b)) else $error("addr");
	a_oe_late: assert property (!addr_valid |->
		!read_slot_bit1_oe) else $error("oe");
	a_oe_on: assert property ($rose(addr_valid) |=>
		read_slot_bit1_oe) else $error("oe on");
	cover property (slot_advance && $past(slot_advance));
	cover property ($rose(trigger));
	cover property ($rose(addr_valid) && strap_in);
endmodule
bind pbt_outputs pbt_props u_pbt_props(.*);

// ===== tb/test_pattern_buffer_trigger_outputs.sv
// Bench for the side-band output block.
`timescale 1ns/1ps
module test_pattern_buffer_trigger_outputs;
	logic clk = 0, nrst = 0, pull = 0, strap_in, flash_loading = 0;
	logic enable_write = 0, enable_value = 1, show_pattern = 1, trigger;
	logic flip_request = 1, advance_request = 0, addr_valid, pattern_flip;
	logic read_slot_bit0, read_slot_bit1, read_slot_bit1_oe, slot_advance;
	logic [6:0] slave_addr;
	logic [1:0] seen;
	int fails = 0, samples_checked = 0;
	initial forever #2 clk = ~clk;
	pbt_outputs u_pbt_outputs(.*);
	pbt_companion u_pbt_companion(.clk, .nrst, .pull, .seen,
		.oe(read_slot_bit1_oe), .hi(read_slot_bit1), .swap(slot_advance),
		.line(strap_in));
	task automatic chk(string n, logic [6:0] e, logic [6:0] g);
		samples_checked++;
		if (e !== g) begin
			fails++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic close_out;
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic t_strap(logic v);
		nrst = 0;
		pull = v;
		repeat (2) @(negedge clk);
		nrst = 1;
		repeat (3) @(negedge clk);
		chk("addr", v ? 7'h1d : 7'h1b, slave_addr);
		chk("valid", 1, addr_valid);
		chk("oe", 0, read_slot_bit1_oe);
		@(negedge clk);
		chk("oe", 1, read_slot_bit1_oe);
	endtask
	task automatic t_run;
		flash_loading = 1;
		advance_request = 1;
		repeat (2) @(negedge clk);
		chk("load", 0, {trigger, pattern_flip, slot_advance});
		flash_loading = 0;
		repeat (2) @(negedge clk);
		chk("idle", 0, {trigger, pattern_flip, slot_advance});
		enable_write = 1;
		@(negedge clk);
		enable_write = 0;
		repeat (5) @(negedge clk);
		advance_request = 0;
		repeat (2) @(negedge clk);
		chk("flags", 3, {trigger, pattern_flip});
		chk("slot", 1, {read_slot_bit1, read_slot_bit0});
		chk("swaps", 1, seen);
	endtask
	initial begin
		t_strap(1);
		t_run;
		t_strap(0);
		close_out;
	end
	initial begin
		#1000;
		fails++;
		close_out;
	end
endmodule
